// File: agd_guard_irq.sv
// Purpose: access guard error flags, irq enables, combined irq, err event
// Assumes: apb slave, pclk 25 MHz, presetn async active low
// Notes: error inputs are one-cycle pulses synchronous to pclk
`timescale 1ns/1ps
module agd_guard_irq
  import agd_pkg::*;
#(
  parameter int NPER = AGD_NPER,
  parameter int BS_W = AGD_SRC_W,
  parameter int P_W = AGD_SRC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AGD_AW-1:0] paddr,
  input wire logic [AGD_DW-1:0] pwdata,
  output logic [AGD_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [BS_W-1:0] bs_err,
  input wire logic [NPER*P_W-1:0] per_err,
  output logic irq,
  output logic err_event
);
  // ***********************
  // registers
  // ***********************
  logic [1:0] en_ff;
  logic erren_ff;
  logic irq_ff;
  logic event_ff;
  logic [AGD_DW-1:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  agd_apb_state_t st_ff;
  logic [NPER:0] new_v;
  logic [NPER:0] req_v;
  logic wr_go;
  logic rd_go;
  logic [AGD_DW-1:0] rdmux;
  logic hit;

  agd_flag_if #(.W(BS_W)) bs_if ();

  // ***********************
  // flag banks
  // ***********************
  agd_flag_bank #(.W(BS_W)) u_bs (
    .pclk(pclk),
    .presetn(presetn),
    .fb(bs_if)
  );
  assign bs_if.err_set = bs_err;
  assign bs_if.clr_mask = (wr_go && paddr == AGD_OFF_BSFLAG) ?
    pwdata[BS_W-1:0] : '0;
  assign new_v[0] = bs_if.any_new;
  assign req_v[0] = (|bs_if.flags) & en_ff[AGD_EN_BS_BIT];

  logic [P_W-1:0] pflags [NPER];

  genvar g;
  generate
    for (g = 0; g < NPER; g++) begin : g_per
      agd_flag_if #(.W(P_W)) p_if ();
      agd_flag_bank #(.W(P_W)) u_p (
        .pclk(pclk),
        .presetn(presetn),
        .fb(p_if)
      );
      assign p_if.err_set = per_err[g*P_W +: P_W];
      assign p_if.clr_mask = (wr_go &&
        paddr == AGD_OFF_PFLAG0 + 8'(4*g)) ? pwdata[P_W-1:0] : '0;
      assign pflags[g] = p_if.flags;
      assign new_v[g+1] = p_if.any_new;
      assign req_v[g+1] = (|p_if.flags) & en_ff[AGD_EN_P_BIT];
    end
  endgenerate

  // ***********************
  // apb slave
  // ***********************
  // one wait-free access phase; answer comes at the penable edge
  assign wr_go = psel && penable && pwrite && st_ff == AGD_ACCESS;
  assign rd_go = psel && penable && !pwrite && st_ff == AGD_ACCESS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= AGD_IDLE;
    end else if (psel && !penable) begin
      st_ff <= AGD_ACCESS;
    end else begin
      st_ff <= AGD_IDLE;
    end
  end

  always_comb begin
    rdmux = AGD_RST_ZERO;
    hit = 1'b1;
    case (paddr)
      AGD_OFF_ENCLR: rdmux[1:0] = en_ff;
      AGD_OFF_ENSET: rdmux[1:0] = en_ff;
      AGD_OFF_EVENT_CONTROL_REG: rdmux[AGD_EVENT_CONTROL_REG_ERREN_BIT] = erren_ff;
      AGD_OFF_BSFLAG: rdmux[BS_W-1:0] = bs_if.flags;
      default: begin
        hit = 1'b0;
        for (int i = 0; i < NPER; i++) begin
          if (paddr == AGD_OFF_PFLAG0 + 8'(4*i)) begin
            rdmux[P_W-1:0] = pflags[i];
            hit = 1'b1;
          end
        end
      end
    endcase
  end

  // pready raised in setup so access phase completes in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= AGD_RST_ZERO;
    end else begin
      pready_ff <= psel && !penable;
      pslverr_ff <= psel && !penable && !hit;
      prdata_ff <= (psel && !penable && !pwrite) ? rdmux : AGD_RST_ZERO;
    end
  end

  // ***********************
  // enables and event control
  // ***********************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= '0;
    end else if (wr_go && paddr == AGD_OFF_ENSET) begin
      en_ff <= en_ff | pwdata[1:0];
    end else if (wr_go && paddr == AGD_OFF_ENCLR) begin
      en_ff <= en_ff & ~pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erren_ff <= 1'b0;
    end else if (wr_go && paddr == AGD_OFF_EVENT_CONTROL_REG) begin
      erren_ff <= pwdata[AGD_EVENT_CONTROL_REG_ERREN_BIT];
    end
  end

  // ***********************
  // outputs
  // ***********************
  // combined request; held while flag and enable stay
  // free-running on pclk, no sleep gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |req_v;
    end
  end

  // new flag event; gated by erren_ff, not by the irq enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_ff <= 1'b0;
    end else begin
      event_ff <= erren_ff & (|new_v);
    end
  end

  assign irq = irq_ff;
  assign err_event = event_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  // rd_go kept for clarity of the access decode
  logic unused_rd;
  assign unused_rd = rd_go;
endmodule

// File: agd_pkg.sv
// Purpose: shared constants for the access guard error irq/event block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: offsets are byte addresses
package agd_pkg;
  localparam int AGD_AW = 8;
  localparam int AGD_DW = 32;
  localparam int AGD_NPER = 4;
  localparam int AGD_SRC_W = 32;
  localparam logic [7:0] AGD_OFF_ENCLR = 8'h00;
  localparam logic [7:0] AGD_OFF_ENSET = 8'h04;
  localparam logic [7:0] AGD_OFF_EVENT_CONTROL_REG = 8'h08;
  localparam logic [7:0] AGD_OFF_BSFLAG = 8'h0C;
  localparam logic [7:0] AGD_OFF_PFLAG0 = 8'h10;
  localparam int AGD_EVENT_CONTROL_REG_ERREN_BIT = 0;
  localparam int AGD_EN_BS_BIT = 0;
  localparam int AGD_EN_P_BIT = 1;
  localparam logic [31:0] AGD_RST_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    AGD_IDLE,
    AGD_ACCESS
  } agd_apb_state_t;
endpackage

// File: agd_flag_if.sv
// Purpose: carries one flag bank between top and flag module
// Assumes: single clock
// Notes: none
`timescale 1ns/1ps
interface agd_flag_if #(parameter int W = 32);
  logic [W-1:0] err_set;
  logic [W-1:0] clr_mask;
  logic [W-1:0] flags;
  logic any_new;
  modport bank (input err_set, input clr_mask, output flags, output any_new);
  modport ctrl (output err_set, output clr_mask, input flags, input any_new);
endinterface

// File: agd_flag_bank.sv
// Purpose: sticky error flag bank with write-one-to-clear
// Assumes: err_set pulses from the guard's error detectors
// Notes: set wins over a clear in the same cycle
`timescale 1ns/1ps
module agd_flag_bank
  import agd_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  agd_flag_if.bank fb
);
  logic [W-1:0] flags_ff;
  logic [W-1:0] nxt_flags;
  logic any_new_ff;
  logic [W-1:0] rises;

  // set on error, one clears, set beats clear
  always_comb begin
    nxt_flags = (flags_ff & ~fb.clr_mask) | fb.err_set;
  end

  assign rises = nxt_flags & ~flags_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      any_new_ff <= 1'b0;
    end else begin
      any_new_ff <= |rises;
    end
  end

  assign fb.flags = flags_ff;
  assign fb.any_new = any_new_ff;
endmodule

// File: agd_props.sv
// Purpose: port checker for agd_guard_irq
// Assumes: one clock, async active-low reset
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module agd_props
  import agd_pkg::*;
#(
  parameter int NPER = AGD_NPER,
  parameter int BS_W = AGD_SRC_W,
  parameter int P_W = AGD_SRC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AGD_AW-1:0] paddr,
  input wire logic [AGD_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [BS_W-1:0] bs_err,
  input wire logic [NPER*P_W-1:0] per_err,
  input wire logic irq,
  input wire logic err_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic hit;
  assign hit = (|bs_err) || (|per_err);
  chk_rdy_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_rdy_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_with_rdy: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  chk_idle_data_zero: assert property (!pready |-> prdata == '0)
    else $error("read data outside access");
  chk_unmapped_refused: assert property (pready && paddr > 8'h1C |-> pslverr)
    else $error("unmapped access accepted");
  chk_event_cause: assert property (err_event |-> $past(hit, 2))
    else $error("event without error pulse");
  chk_irq_rise_cause: assert property ($rose(irq) |->
    $past(hit, 2) || $past(pready && pwrite, 2))
    else $error("irq rose without cause");
  chk_irq_fall_cause: assert property ($fell(irq) |->
    $past(pready && pwrite, 2))
    else $error("irq fell without a write");
  cover property ($rose(irq));
  cover property (err_event);
  cover property (pslverr);
endmodule
bind agd_guard_irq agd_props #(.NPER(NPER), .BS_W(BS_W), .P_W(P_W)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .bs_err(bs_err), .per_err(per_err), .irq(irq),
  .err_event(err_event));

// File: agd_sys_model.sv
// Purpose: system side, counts error events and samples irq
// Assumes: err_event is a one-cycle pulse on pclk
// Notes: never stalls, nothing is answered
`timescale 1ns/1ps
module agd_sys_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq,
  input wire logic err_event,
  output int ev_count,
  output logic irq_seen
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_count <= 0;
      irq_seen <= 1'b0;
    end else begin
      ev_count <= ev_count + int'(err_event);
      irq_seen <= irq;
    end
  end
endmodule

// File: tb_top.sv
// Purpose: self-checking bench for agd_guard_irq
// Assumes: zero-wait apb slave, 40 ns clock
// Notes: flags, enables and events mirrored in a bench model
`timescale 1ns/1ps
module tb_top
  import agd_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, err_event, irq_seen, se;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, bs_err = 32'h0, bsm = 32'h0;
  logic [31:0] s = 32'h0000B216;
  logic [127:0] per_err = 128'h0, pm = 128'h0;
  logic [1:0] en = 2'h0;
  logic evm = 1'b0;
  int bad_count = 0, samples_checked = 0, ev_exp = 0, ev_count, g;
  always #20 pclk = ~pclk;
  agd_guard_irq i_agd_guard_irq (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bs_err(bs_err),
    .per_err(per_err), .irq(irq), .err_event(err_event));
  agd_sys_model i_agd_sys_model (.pclk(pclk), .presetn(presetn), .irq(irq),
    .err_event(err_event), .ev_count(ev_count), .irq_seen(irq_seen));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ****
  // apb master, held until pready
  // ****
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // one-cycle error pulse; the event counts only bits that were clear
  task automatic hit(input logic [31:0] b, input logic [127:0] p);
    @(posedge pclk);
    bs_err <= b;
    per_err <= p;
    @(posedge pclk);
    bs_err <= 32'h0;
    per_err <= 128'h0;
    if (evm && ((b & ~bsm) != 0 || (p & ~pm) != 0)) ev_exp++;
    bsm = bsm | b;
    pm = pm | p;
    repeat (3) @(posedge pclk);
  endtask
  task automatic irqchk;
    repeat (3) @(posedge pclk);
    chk({31'h0, irq_seen}, {31'h0, (en[0] && bsm != 0) || (en[1] && pm != 0)});
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 32; a += 4) rdchk(8'(a), 32'h0);
    apb(1'b1, AGD_OFF_EVENT_CONTROL_REG, 32'h1);
    evm = 1'b1;
    rdchk(AGD_OFF_EVENT_CONTROL_REG, 32'h1);
    for (int i = 0; i < 16; i++) begin
      s = lfsr(s);
      g = int'(s[5:4]);
      apb(1'b1, i[0] ? AGD_OFF_ENCLR : AGD_OFF_ENSET, {30'h0, s[1:0]});
      en = i[0] ? en & ~s[1:0] : en | s[1:0];
      hit(s, {96'h0, lfsr(s)} << (32 * g));
      irqchk();
      chk(32'(ev_count), 32'(ev_exp));
      rdchk(AGD_OFF_ENSET, {30'h0, en});
      rdchk(AGD_OFF_ENCLR, {30'h0, en});
      rdchk(AGD_OFF_BSFLAG, bsm);
      rdchk(AGD_OFF_PFLAG0 + 8'(4 * g), pm[g*32+:32]);
      s = lfsr(lfsr(s));
      apb(1'b1, AGD_OFF_BSFLAG, s);
      bsm = bsm & ~s;
      apb(1'b1, AGD_OFF_PFLAG0 + 8'(4 * g), s);
      pm[g*32+:32] = pm[g*32+:32] & ~s;
      irqchk();
      rdchk(AGD_OFF_BSFLAG, bsm);
    end
    apb(1'b1, AGD_OFF_EVENT_CONTROL_REG, 32'h0);
    evm = 1'b0;
    hit(32'hFFFFFFFF, {128{1'b1}});
    chk(32'(ev_count), 32'(ev_exp));
    rdchk(8'h40, 32'h0);
    chk({31'h0, se}, 32'h1);
    test_done();
  end
endmodule
